// ---- design/asmu_pkg.sv ----
// Shared constants and types of the accumulator stack math unit
package asmu_pkg;
	// ============================================================
	// Register map (byte offsets) and reset values
	localparam logic [7:0] ASMU_ACC_OFFSET = 8'h00;
	localparam logic [7:0] ASMU_STACK1_OFFSET = 8'h04;
	localparam logic [7:0] ASMU_FLAGS_OFFSET = 8'h08;
	localparam logic [7:0] ASMU_CMD_OFFSET = 8'h0c;
	localparam logic [31:0] ASMU_ACC_RESET = 32'h0000_0000;
	localparam logic [3:0] ASMU_OP_RESET = 4'h0;
	// ============================================================
	// Operation codes written to the command register
	localparam logic [3:0] OP_SUB = 4'h1;
	localparam logic [3:0] OP_MUL = 4'h2;
	localparam logic [3:0] OP_DIV = 4'h3;
	localparam logic [3:0] OP_SIN = 4'h4;
	localparam logic [3:0] OP_COS = 4'h5;
	localparam logic [3:0] OP_TAN = 4'h6;
	localparam logic [3:0] OP_ASIN = 4'h7;
	localparam logic [3:0] OP_ACOS = 4'h8;
	localparam logic [3:0] OP_ATAN = 4'h9;
	localparam logic [3:0] OP_SQRT = 4'ha;
	localparam logic [3:0] OP_D2R = 4'hb;
	localparam logic [3:0] OP_POPCNT = 4'hc;
	// ============================================================
	// Fixed point constants, Q28 signed, except the degree to radian factor in Q32
	localparam int ASMU_FRAC_BITS = 28;
	localparam logic [31:0] ASMU_ONE = 32'h1000_0000;
	localparam logic [31:0] ASMU_PI = 32'h3243_f6a8;
	localparam logic [31:0] ASMU_TWO_PI = 32'h6487_ed51;
	localparam logic [31:0] ASMU_HALF_PI = 32'h1921_fb54;
	localparam logic [31:0] ASMU_GAIN = 32'h09b7_4eda;
	localparam logic [31:0] ASMU_DEG2RAD_Q32 = 32'h0477_d1a9;
	// ============================================================
	// Cycle counts and default sizes
	localparam int ASMU_DIV_STEPS = 64;
	localparam int ASMU_SQRT_STEPS = 32;
	localparam int ASMU_CORDIC_STEPS = 28;
	localparam int ASMU_STACK_DEPTH = 8;
	// ============================================================
	// Types
	typedef struct packed {
		logic sign_error_flag;
		logic invalid_operand_flag;
		logic valid_float_flag;
		logic operand_range_flag;
		logic negative_result_flag;
		logic borrow32_flag;
		logic borrow16_flag;
		logic zero_result_flag;
	} asmu_flags_type;
	localparam asmu_flags_type ASMU_FLAGS_RESET = '0;
	typedef struct packed {
		logic sign;
		logic [7:0] exp;
		logic [22:0] frac;
	} asmu_float_type;
	typedef enum logic [2:0] {
		ST_IDLE, ST_REDUCE, ST_CORDIC, ST_SQRT, ST_DIV
	} asmu_state_type;
endpackage

// ---- design/asmu_math_unit.sv ----
// Accumulator stack math unit with APB register access
// What this block does
// (RL1) Stack subtract: accumulator minus stack level one, 32 bit, into accumulator.
// (RL2) Subtract and multiply pop stack level one, moving all entries up.
// (RL3) Subtract raises separate 16 bit and 32 bit borrow flags.
// (RL4) Zero flag set when resulting accumulator is zero.
// (RL5) Negative flag set when resulting accumulator is negative.
// (RL6) Multiply 16 bit stack level one by 16 bit accumulator, 32 bit product.
// (RL7) Divide 32 bit accumulator by 16 bit level one; quotient, remainder stored.
// (RL8) Divide and real functions raise range flag for unmanageable operands.
// (RL9) Each flag holds until a later operation using it overwrites it.
// (RL10) Double word load pushes old accumulator onto stack first.
// (RL11) Sequencer supplies only real operands to transcendental functions.
// (RL12) Square root correct for every positive real operand; a denormal operand is left in the accumulator unchanged.
// (RL13) Trig arguments are radians; degrees converted by a separate operation.
// (RL14) Valid float flag set when accumulator holds valid float afterwards.
// (RL15) Sign error flag on wrong sign bit of signed subtraction.
// (RL16) Invalid operand flag when real operation meets a non-real value.
// (RL17) Sine, cosine, tangent replace accumulator; single precision in and out.
// (RL18) Inverse sine, cosine, tangent replace accumulator in single precision.
// (RL19) Square root replaces accumulator, single precision result.
// (RL20) Population count of one bits placed in accumulator as binary.
// (RL21) Divide by zero raises range flag, leaves accumulator and stack.
//
// Our own choices: the placing of the registers and the APB register port.
module asmu_math_unit
	import asmu_pkg::*;
#(
	parameter int STACK_DEPTH = ASMU_STACK_DEPTH,
	parameter int CORDIC_STEPS = ASMU_CORDIC_STEPS
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic busy_out,
	output asmu_flags_type flags_out
);
	// ============================================================
	// Helper functions
	// Arc tangent of 2^-i in Q28; series form past the table is exact enough
	function automatic logic signed [31:0] atan_step(input int i);
		logic signed [31:0] v;
		v = '0;
		case (i)
			0: v = 32'h0c90_fdaa;
			1: v = 32'h076b_19c3;
			2: v = 32'h03eb_6ebf;
			3: v = 32'h01fd_5baa;
			4: v = 32'h00ff_aade;
			default: begin
				v = 32'(1 << (ASMU_FRAC_BITS - i));
				if (3 * i <= ASMU_FRAC_BITS) begin
					v = v - 32'((1 << (ASMU_FRAC_BITS - 3 * i)) / 3);
				end
			end
		endcase
		return v;
	endfunction

	// Single float to Q28; caller guarantees magnitude below 8
	function automatic logic signed [31:0] to_fixed(input asmu_float_type f);
		logic [31:0] m;
		int sh;
		m = {8'h00, 1'b1, f.frac};
		sh = int'(f.exp) - 127 + ASMU_FRAC_BITS - 23;
		if (f.exp == 8'h00) begin
			m = '0;
		end else if (sh >= 0) begin
			m = m << sh;
		end else begin
			m = m >> (-sh);
		end
		return f.sign ? -m : m;
	endfunction

	// Magnitude times 2^scale to single float; truncates, flushes underflow
	function automatic logic [31:0] to_float(input logic sgn, input logic [63:0] mag,
		input int scale);
		int msb;
		int e;
		logic [63:0] m;
		msb = -1;
		for (int b = 0; b < 64; b++) begin
			if (mag[b]) msb = b;
		end
		e = 127 + msb + scale;
		if (msb < 0 || e <= 0) return 32'h0000_0000;
		if (e >= 255) return {sgn, 8'hff, 23'h00_0000};
		m = (msb >= 23) ? (mag >> (msb - 23)) : (mag << (23 - msb));
		return {sgn, e[7:0], m[22:0]};
	endfunction

	function automatic logic [63:0] mag64(input logic signed [31:0] v);
		logic [31:0] a;
		a = v[31] ? -v : v;
		return {32'h0000_0000, a};
	endfunction

	// Flags of a real result
	function automatic asmu_flags_type real_flags(input logic [31:0] r, input logic rng,
		input logic inv);
		asmu_flags_type fl;
		fl = '0;
		fl.zero_result_flag = (r[30:0] == 31'h0); // RL4
		fl.negative_result_flag = r[31] && !fl.zero_result_flag; // RL5
		fl.valid_float_flag = (r[30:23] != 8'hff); // RL14
		fl.operand_range_flag = rng; // RL8
		fl.invalid_operand_flag = inv; // RL16
		return fl;
	endfunction

	// Which flags an operation owns; others keep their value
	function automatic asmu_flags_type op_mask(input logic [3:0] op);
		asmu_flags_type m;
		m = '0;
		m.zero_result_flag = 1'b1;
		m.negative_result_flag = 1'b1;
		case (op)
			OP_SUB: begin
				m.borrow16_flag = 1'b1;
				m.borrow32_flag = 1'b1;
				m.sign_error_flag = 1'b1;
			end
			OP_MUL, OP_POPCNT: ;
			OP_DIV: m.operand_range_flag = 1'b1;
			default: begin
				m.operand_range_flag = 1'b1;
				m.valid_float_flag = 1'b1;
				m.sign_error_flag = 1'b1;
				m.invalid_operand_flag = 1'b1;
			end
		endcase
		return m;
	endfunction

	function automatic logic op_known(input logic [31:0] w);
		return (w[31:4] == 28'h0) && (w[3:0] >= OP_SUB) && (w[3:0] <= OP_POPCNT);
	endfunction

	// ============================================================
	// State
	asmu_state_type state_q;
	logic [31:0] acc_q;
	logic [31:0] stack_q [STACK_DEPTH];
	asmu_flags_type flags_q;
	logic [3:0] op_q;
	logic neg_q;
	logic sign_q;
	logic [6:0] iter_q;
	logic signed [31:0] cx_q;
	logic signed [31:0] cy_q;
	logic signed [31:0] cz_q;
	logic [63:0] dv_q;
	logic [31:0] drem_q;
	logic [31:0] dden_q;
	logic [63:0] sq_rad_q;
	logic [35:0] sq_rem_q;
	logic [31:0] sq_root_q;
	logic signed [9:0] scale_q;
	logic [31:0] prdata_q;
	logic fresh_q;

	// ============================================================
	// APB decode
	logic idle;
	logic xfer;
	logic hit;
	logic bad;
	logic cmd_fire;
	logic load_acc;
	logic [3:0] cmd_op;
	logic [31:0] rd_mux;
	assign idle = (state_q == ST_IDLE);
	assign cmd_op = pwdata_in[3:0];
	// Data must be sampled while idle, so a ready access always sees settled state
	assign pready_out = ce_in && idle && fresh_q;
	assign xfer = psel_in && penable_in && pready_out;
	assign pslverr_out = xfer && bad;
	assign busy_out = !idle;
	assign flags_out = flags_q;
	assign prdata_out = prdata_q;

	// Address decode and error conditions
	always_comb begin
		rd_mux = '0;
		hit = 1'b1;
		if (paddr_in == ASMU_ACC_OFFSET) begin
			rd_mux = acc_q;
		end else if (paddr_in == ASMU_STACK1_OFFSET) begin
			rd_mux = stack_q[0];
		end else if (paddr_in == ASMU_FLAGS_OFFSET) begin
			rd_mux = 32'(flags_q);
		end else if (paddr_in == ASMU_CMD_OFFSET) begin
			rd_mux = {28'h000_0000, op_q};
		end else begin
			hit = 1'b0;
		end
	end
	assign bad = !hit || (pwrite_in && ((pstrb_in != 4'hf)
		|| (paddr_in == ASMU_STACK1_OFFSET) || (paddr_in == ASMU_FLAGS_OFFSET)
		|| (paddr_in == ASMU_CMD_OFFSET && !op_known(pwdata_in))));
	assign cmd_fire = xfer && pwrite_in && !bad && (paddr_in == ASMU_CMD_OFFSET);
	assign load_acc = xfer && pwrite_in && !bad && (paddr_in == ASMU_ACC_OFFSET);

	// Read data and freshness, loaded each idle cycle of a transfer except the completing one
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			prdata_q <= '0;
			fresh_q <= 1'b0;
		end else if (ce_in) begin
			if (psel_in && idle && !xfer) prdata_q <= rd_mux;
			fresh_q <= psel_in && idle && !xfer;
		end
	end

	// ============================================================
	// Operand decode
	asmu_float_type facc;
	int e_unb;
	logic [23:0] mant;
	logic signed [31:0] acc_fix;
	logic signed [63:0] xsq;
	logic [31:0] one_m_xsq;
	logic [32:0] diff;
	logic [31:0] sub_res;
	assign facc = asmu_float_type'(acc_q);
	assign e_unb = int'(facc.exp) - 127;
	assign mant = (facc.exp == 8'h00) ? 24'h00_0000 : {1'b1, facc.frac};
	assign acc_fix = to_fixed(facc);
	assign xsq = 64'(acc_fix) * 64'(acc_fix);
	assign one_m_xsq = ASMU_ONE - xsq[59:28];
	assign diff = {1'b0, acc_q} - {1'b0, stack_q[0]}; // RL1
	assign sub_res = diff[31:0];

	// ============================================================
	// Completion of an operation and choice of the next phase
	logic fin;
	logic fin_pop;
	logic fin_rem;
	logic [31:0] fin_acc;
	asmu_flags_type fin_fl;
	asmu_flags_type fin_m;
	asmu_state_type start_st;
	logic [31:0] rres;
	always_comb begin
		fin = 1'b0;
		fin_pop = 1'b0;
		fin_rem = 1'b0;
		fin_acc = acc_q;
		fin_fl = '0;
		start_st = ST_IDLE;
		rres = '0;
		case (state_q)
			ST_IDLE: if (cmd_fire) begin
				if (cmd_op >= OP_SIN && cmd_op <= OP_D2R && facc.exp == 8'hff) begin
					fin = 1'b1;
					fin_fl = real_flags(acc_q, 1'b0, 1'b1); // RL16
				end else begin
					case (cmd_op)
						OP_SUB: begin
							fin = 1'b1;
							fin_pop = 1'b1; // RL2
							fin_acc = sub_res;
							fin_fl.borrow16_flag = (acc_q[15:0] < stack_q[0][15:0]); // RL3
							fin_fl.borrow32_flag = diff[32]; // RL3
							fin_fl.sign_error_flag = (acc_q[31] != stack_q[0][31])
								&& (sub_res[31] != acc_q[31]); // RL15
						end
						OP_MUL: begin
							fin = 1'b1;
							fin_pop = 1'b1; // RL2
							fin_acc = 32'(acc_q[15:0]) * 32'(stack_q[0][15:0]); // RL6
						end
						OP_POPCNT: begin
							fin = 1'b1;
							fin_acc = 32'($countones(acc_q)); // RL20
						end
						OP_DIV: begin
							if (stack_q[0][15:0] == 16'h0000) begin
								fin = 1'b1;
								fin_fl.operand_range_flag = 1'b1; // RL21
							end else begin
								start_st = ST_DIV;
							end
						end
						OP_D2R: begin
							fin = 1'b1;
							rres = to_float(facc.sign, 64'(mant) * 64'(ASMU_DEG2RAD_Q32),
								e_unb - 55); // RL13
							fin_acc = rres;
							fin_fl = real_flags(rres, rres[30:23] == 8'hff, 1'b0);
						end
						OP_SQRT: begin
							if (facc.sign || facc.exp == 8'h00) begin
								fin = 1'b1;
								fin_fl = real_flags(acc_q, mant != 24'h0, 1'b0);
							end else begin
								start_st = ST_SQRT;
							end
						end
						OP_ATAN: start_st = ST_CORDIC;
						OP_ASIN, OP_ACOS: begin
							if (e_unb > 0 || (e_unb == 0 && facc.frac != 23'h0)) begin
								fin = 1'b1;
								fin_fl = real_flags(acc_q, 1'b1, 1'b0); // RL8
							end else begin
								start_st = ST_SQRT;
							end
						end
						default: begin
							// Trig beyond the fixed point span is out of range
							if (e_unb > 2) begin
								fin = 1'b1;
								fin_fl = real_flags(acc_q, 1'b1, 1'b0); // RL8
							end else begin
								start_st = ST_REDUCE;
							end
						end
					endcase
				end
			end
			ST_CORDIC: if (iter_q == 7'(CORDIC_STEPS)) begin
				case (op_q)
					OP_SIN: rres = to_float(neg_q ^ cy_q[31], mag64(cy_q), -28); // RL17
					OP_COS: rres = to_float(neg_q ^ cx_q[31], mag64(cx_q), -28); // RL17
					OP_ACOS: rres = to_float(cz_q > $signed(ASMU_HALF_PI),
						mag64($signed(ASMU_HALF_PI) - cz_q), -28); // RL18
					default: rres = to_float(cz_q[31], mag64(cz_q), -28); // RL18
				endcase
				if (op_q != OP_TAN || cx_q == 0) begin
					fin = 1'b1;
					fin_acc = (op_q == OP_TAN) ? acc_q : rres;
					fin_fl = real_flags(fin_acc, op_q == OP_TAN, 1'b0);
				end
			end
			ST_SQRT: if (iter_q == 7'(ASMU_SQRT_STEPS) && op_q == OP_SQRT) begin
				fin = 1'b1;
				fin_acc = to_float(1'b0, {32'h0, sq_root_q}, int'(scale_q)); // RL12 RL19
				fin_fl = real_flags(fin_acc, 1'b0, 1'b0);
			end
			ST_DIV: if (iter_q == 7'(ASMU_DIV_STEPS)) begin
				fin = 1'b1;
				if (op_q == OP_DIV) begin
					fin_rem = 1'b1;
					fin_acc = dv_q[31:0]; // RL7
				end else begin
					fin_acc = to_float(sign_q, dv_q, -32); // RL17
					fin_fl = real_flags(fin_acc, fin_acc[30:23] == 8'hff, 1'b0);
				end
			end
			default: ;
		endcase
		if (op_q == OP_DIV || op_q < OP_SIN || op_q == OP_POPCNT || state_q == ST_IDLE) begin
			if (!(state_q == ST_IDLE && cmd_op >= OP_SIN && cmd_op <= OP_D2R)) begin
				fin_fl.zero_result_flag = (fin_acc == 32'h0); // RL4
				fin_fl.negative_result_flag = fin_acc[31]; // RL5
			end
		end
		fin_m = op_mask(idle ? cmd_op : op_q);
	end

	// ============================================================
	// Accumulator: load with push, or result of an operation
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			acc_q <= ASMU_ACC_RESET;
		end else if (ce_in) begin
			if (load_acc) acc_q <= pwdata_in; // RL10
			else if (fin) acc_q <= fin_acc;
		end
	end

	// Stack: push on load, pop after subtract and multiply, remainder to level one
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < STACK_DEPTH; i++) stack_q[i] <= '0;
		end else if (ce_in) begin
			if (load_acc) begin
				stack_q[0] <= acc_q; // RL10
				for (int i = 1; i < STACK_DEPTH; i++) stack_q[i] <= stack_q[i - 1];
			end else if (fin && fin_pop) begin
				for (int i = 0; i < STACK_DEPTH - 1; i++) stack_q[i] <= stack_q[i + 1]; // RL2
				stack_q[STACK_DEPTH - 1] <= '0;
			end else if (fin && fin_rem) begin
				stack_q[0] <= drem_q; // RL7
			end
		end
	end

	// Flags: only those the operation owns are overwritten
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			flags_q <= ASMU_FLAGS_RESET;
		end else if (ce_in && fin) begin
			flags_q <= (fin_fl & fin_m) | (flags_q & ~fin_m); // RL9
		end
	end

	// ============================================================
	// Sequencer and iterative datapath
	logic [35:0] sq_t;
	logic [35:0] sq_trial;
	logic [32:0] dv_t;
	logic vec;
	logic dir;
	assign sq_t = {sq_rem_q[33:0], sq_rad_q[63:62]};
	assign sq_trial = {2'b00, sq_root_q, 2'b01};
	assign dv_t = {drem_q, dv_q[63]};
	// Vectoring drives y to zero; rotation drives z to zero
	assign vec = (op_q == OP_ASIN) || (op_q == OP_ACOS) || (op_q == OP_ATAN);
	assign dir = vec ? cy_q[31] : !cz_q[31];

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			op_q <= ASMU_OP_RESET;
			iter_q <= '0;
			neg_q <= 1'b0;
			sign_q <= 1'b0;
			cx_q <= '0;
			cy_q <= '0;
			cz_q <= '0;
			dv_q <= '0;
			drem_q <= '0;
			dden_q <= '0;
			sq_rad_q <= '0;
			sq_rem_q <= '0;
			sq_root_q <= '0;
			scale_q <= '0;
		end else if (ce_in) begin
			case (state_q)
				ST_IDLE: if (cmd_fire) begin
					op_q <= cmd_op;
					iter_q <= '0;
					neg_q <= 1'b0;
					state_q <= start_st;
					cz_q <= (start_st == ST_REDUCE) ? acc_fix : 32'h0;
					cy_q <= acc_fix;
					drem_q <= '0;
					dv_q <= {32'h0, acc_q};
					dden_q <= {16'h0000, stack_q[0][15:0]}; // RL7
					sq_rem_q <= '0;
					sq_root_q <= '0;
					// Radicand shift keeps the exponent even for the halving
					if (cmd_op == OP_SQRT && e_unb[0]) begin
						sq_rad_q <= 64'(mant) << 40;
						scale_q <= 10'((e_unb - 63) / 2);
					end else if (cmd_op == OP_SQRT) begin
						sq_rad_q <= 64'(mant) << 39;
						scale_q <= 10'((e_unb - 62) / 2);
					end else begin
						sq_rad_q <= {4'h0, one_m_xsq, 28'h000_0000}; // RL18
					end
					// Large atan arguments are scaled on both axes alike
					if (e_unb < 0) begin
						cx_q <= ASMU_ONE;
					end else begin
						cx_q <= (e_unb <= 28) ? (ASMU_ONE >> e_unb) : 32'h0;
						cy_q <= facc.sign ? -(32'(mant) << 5) : (32'(mant) << 5);
					end
				end
				ST_REDUCE: begin
					// Fold into one turn, then into the half turn where the rotation converges
					if (cz_q > $signed(ASMU_PI)) begin
						cz_q <= cz_q - $signed(ASMU_TWO_PI);
					end else if (cz_q < -$signed(ASMU_PI)) begin
						cz_q <= cz_q + $signed(ASMU_TWO_PI);
					end else begin
						if (cz_q > $signed(ASMU_HALF_PI)) begin
							cz_q <= cz_q - $signed(ASMU_PI);
							neg_q <= 1'b1;
						end else if (cz_q < -$signed(ASMU_HALF_PI)) begin
							cz_q <= cz_q + $signed(ASMU_PI);
							neg_q <= 1'b1;
						end
						cx_q <= ASMU_GAIN;
						cy_q <= '0;
						iter_q <= '0;
						state_q <= ST_CORDIC;
					end
				end
				ST_CORDIC: begin
					if (iter_q != 7'(CORDIC_STEPS)) begin
						cx_q <= dir ? cx_q - (cy_q >>> iter_q) : cx_q + (cy_q >>> iter_q);
						cy_q <= dir ? cy_q + (cx_q >>> iter_q) : cy_q - (cx_q >>> iter_q);
						cz_q <= dir ? cz_q - atan_step(int'(iter_q))
							: cz_q + atan_step(int'(iter_q));
						iter_q <= iter_q + 7'd1;
					end else if (op_q == OP_TAN && cx_q != 0) begin
						dv_q <= {32'(mag64(cy_q)), 32'h0000_0000}; // RL17
						dden_q <= 32'(mag64(cx_q));
						drem_q <= '0;
						sign_q <= cy_q[31] ^ cx_q[31];
						iter_q <= '0;
						state_q <= ST_DIV;
					end else begin
						state_q <= ST_IDLE;
					end
				end
				ST_SQRT: begin
					if (iter_q != 7'(ASMU_SQRT_STEPS)) begin
						if (sq_t >= sq_trial) begin
							sq_rem_q <= sq_t - sq_trial;
							sq_root_q <= {sq_root_q[30:0], 1'b1};
						end else begin
							sq_rem_q <= sq_t;
							sq_root_q <= {sq_root_q[30:0], 1'b0};
						end
						sq_rad_q <= sq_rad_q << 2;
						iter_q <= iter_q + 7'd1;
					end else if (op_q == OP_SQRT) begin
						state_q <= ST_IDLE;
					end else begin
						// Inverse sine as the angle of (sqrt(1-x*x), x)
						cx_q <= sq_root_q;
						cz_q <= '0;
						iter_q <= '0;
						state_q <= ST_CORDIC;
					end
				end
				ST_DIV: begin
					if (iter_q != 7'(ASMU_DIV_STEPS)) begin
						if (dv_t >= {1'b0, dden_q}) begin
							drem_q <= 32'(dv_t - {1'b0, dden_q});
							dv_q <= {dv_q[62:0], 1'b1};
						end else begin
							drem_q <= dv_t[31:0];
							dv_q <= {dv_q[62:0], 1'b0};
						end
						iter_q <= iter_q + 7'd1;
					end else begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
endmodule // asmu_math_unit

// ---- tb/asmu_math_unit_sva.sv ----
// Checker of the math unit port behaviour
module asmu_math_unit_sva
	import asmu_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic busy_out,
	input asmu_flags_type flags_out
);
	// ============================================================
	// Transfer decode
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	logic done;
	logic cmd;
	// Completing access and command write with all byte strobes set
	assign done = psel_in && penable_in && pready_out;
	assign cmd = done && pwrite_in && paddr_in == ASMU_CMD_OFFSET && pstrb_in == 4'hf;
	// ============================================================
	// Properties
	a_busy_stalls: assert property (busy_out |-> !pready_out)
		else $error("ready while busy");
	a_flags_hold: assert property (!cmd && !busy_out |=> $stable(flags_out))
		else $error("flags moved without an operation");
	a_zero_not_neg: assert property (!(flags_out.zero_result_flag
		&& flags_out.negative_result_flag))
		else $error("zero and negative together");
	a_sub_single: assert property (cmd && pwdata_in == {28'h0, OP_SUB} |=> !busy_out)
		else $error("subtract not done at once");
	a_div_bounded: assert property (cmd && pwdata_in == {28'h0, OP_DIV}
		|=> ##[0:70] !busy_out)
		else $error("divide too slow");
	a_busy_ends: assert property (busy_out |-> ##[1:200] !busy_out)
		else $error("operation never ends");
	a_ro_refused: assert property (done && pwrite_in && (paddr_in == ASMU_STACK1_OFFSET
		|| paddr_in == ASMU_FLAGS_OFFSET) |-> pslverr_out)
		else $error("read only write accepted");
	a_unmapped_err: assert property (done && paddr_in > 8'h0c |-> pslverr_out)
		else $error("unmapped access accepted");
	a_ready_soon: assert property (psel_in && penable_in && ce_in && !busy_out
		|-> ##[0:3] pready_out)
		else $error("idle unit does not answer");
	a_ce_freeze: assert property (!ce_in |-> !pready_out)
		else $error("ready with clock enable low");
endmodule // asmu_math_unit_sva

// ---- tb/asmu_seq_model.sv ----
// Sequencer model issuing APB transfers to the math unit
module asmu_seq_model (
	input wire logic clk_in,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in,
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [7:0] paddr_out,
	output logic [31:0] pwdata_out,
	output logic [3:0] pstrb_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// Idle bus at time zero
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h0;
		pstrb_out = 4'hf;
	end
	// One transfer; request held until ready, stalls on busy are waited out
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r, output logic e);
		@(posedge clk_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		pstrb_out <= s;
		@(posedge clk_in);
		penable_out <= 1'b1;
		do @(posedge clk_in); while (pready_in !== 1'b1);
		r = prdata_in;
		e = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		pwdata_out <= ~d; // Stale data never lingers
	endtask
endmodule // asmu_seq_model

// ---- tb/tb.sv ----
// Testbench of the accumulator stack math unit
`define CHK(n, x, g) begin samples_checked++; if ((g) !== (x)) begin bad_count++; \
	$display("mismatch %s expected %h seen %h", n, x, g); end end
module tb;
	import asmu_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, ce, psel, pen, pwr, rdy, err, busy, e;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, r;
	logic [3:0] strb;
	asmu_flags_type f;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [3:0] rop [8] = '{OP_SIN, OP_COS, OP_TAN, OP_ASIN, OP_ACOS, OP_ATAN, OP_SQRT, OP_D2R};
	logic [31:0] rin [8] = '{32'h3fc9_0fdb, 32'h0, 32'h3f49_0fdb, 32'h3f80_0000, 32'h0,
		32'h3f80_0000, 32'h4080_0000, 32'h4334_0000};
	logic [31:0] rex [8] = '{32'h3f80_0000, 32'h3f80_0000, 32'h3f80_0000, 32'h3fc9_0fdb,
		32'h3fc9_0fdb, 32'h3f49_0fdb, 32'h4000_0000, 32'h4049_0fdb};
	// ============================================================
	// Clock, design and sequencer
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	asmu_math_unit u_dut (.ref_clk_in(clk), .rst_in(rst), .ce_in(ce), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdata),
		.pstrb_in(strb), .prdata_out(rdata), .pready_out(rdy), .pslverr_out(err),
		.busy_out(busy), .flags_out(f));
	asmu_seq_model u_seq (.clk_in(clk), .prdata_in(rdata), .pready_in(rdy),
		.pslverr_in(err), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
		.paddr_out(addr), .pwdata_out(wdata), .pstrb_out(strb));
	// ============================================================
	// Access helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_seq.xfer(1'b1, a, d, 4'hf, r, e);
	endtask
	task automatic rd(input logic [7:0] a);
		u_seq.xfer(1'b0, a, 32'h0, 4'hf, r, e);
	endtask
	task automatic ld(input logic [31:0] d);
		wr(ASMU_ACC_OFFSET, d);
	endtask
	task automatic op(input logic [3:0] c);
		wr(ASMU_CMD_OFFSET, {28'h0, c});
	endtask
	// Truncating iterative maths, so compare floats within 64 units
	function automatic logic near(input logic [31:0] a, input logic [31:0] b);
		return ((a > b) ? a - b : b - a) <= 32'd64;
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			final_report();
		end
	end
	// ============================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		ld(32'h9); ld(32'h5); ld(32'h3); rd(ASMU_STACK1_OFFSET);
		`CHK("push", 32'h5, r)
		op(OP_SUB); rd(ASMU_ACC_OFFSET);
		`CHK("sub", 32'hffff_fffe, r)
		`CHK("b16", 1'b1, f.borrow16_flag)
		`CHK("b32", 1'b1, f.borrow32_flag)
		`CHK("neg", 1'b1, f.negative_result_flag)
		rd(ASMU_STACK1_OFFSET);
		`CHK("pop", 32'h9, r)
		ld(32'h1); ld(32'h8000_0000); op(OP_SUB); rd(ASMU_ACC_OFFSET);
		`CHK("subov", 32'h7fff_ffff, r)
		`CHK("sgn", 1'b1, f.sign_error_flag)
		`CHK("b32ov", 1'b0, f.borrow32_flag)
		`CHK("b16ov", 1'b1, f.borrow16_flag)
		ld(32'h7); ld(32'h7); op(OP_SUB); rd(ASMU_ACC_OFFSET);
		`CHK("zero", 1'b1, f.zero_result_flag)
		ld(32'hffff); ld(32'hffff); op(OP_MUL); rd(ASMU_ACC_OFFSET);
		`CHK("mul", 32'hfffe_0001, r)
		`CHK("mulneg", 1'b1, f.negative_result_flag)
		ld(32'h7); ld(32'd100); op(OP_DIV); rd(ASMU_ACC_OFFSET);
		`CHK("quot", 32'd14, r)
		rd(ASMU_STACK1_OFFSET);
		`CHK("rem", 32'h2, r)
		ld(32'h0); ld(32'd50); op(OP_DIV); rd(ASMU_ACC_OFFSET);
		`CHK("div0", 32'd50, r)
		`CHK("rng", 1'b1, f.operand_range_flag)
		ld(32'hf0f0_0001); op(OP_POPCNT); rd(ASMU_ACC_OFFSET);
		`CHK("pop", 32'h9, r)
		`CHK("hold", 1'b1, f.operand_range_flag)
		// Real operands only, as the sequencer must supply
		for (int i = 0; i < 8; i++) begin
			ld(rin[i]); op(rop[i]); rd(ASMU_ACC_OFFSET);
			`CHK("real", 1'b1, near(r, rex[i]))
			`CHK("valid", 1'b1, f.valid_float_flag)
		end
		ld(32'h7fc0_0000); op(OP_SIN); rd(ASMU_ACC_OFFSET);
		`CHK("nan", 32'h7fc0_0000, r)
		`CHK("inv", 1'b1, f.invalid_operand_flag)
		ld(32'h4000_0000); op(OP_ASIN); rd(ASMU_ACC_OFFSET);
		`CHK("asin2", 1'b1, f.operand_range_flag)
		rd(8'h10);
		`CHK("unmap", 33'h1_0000_0000, {e, r})
		wr(ASMU_STACK1_OFFSET, 32'h1);
		`CHK("roerr", 1'b1, e)
		u_seq.xfer(1'b1, ASMU_ACC_OFFSET, 32'h5, 4'h3, r, e); rd(ASMU_ACC_OFFSET);
		`CHK("strb", 32'h4000_0000, r)
		@(posedge clk);
		ce <= 1'b0;
		@(posedge clk);
		ce <= 1'b1;
		final_report();
	end
endmodule // tb
bind asmu_math_unit asmu_math_unit_sva u_sva (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
	.ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
	.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.busy_out(busy_out), .flags_out(flags_out));
